//--- src/gled_consts.svh
`ifndef GLED_CONSTS_SVH
`define GLED_CONSTS_SVH

// register byte offsets
`define GLED_CFG_OFF     12'h000
`define GLED_DATA_OFF    12'h004
`define GLED_STATUS_OFF  12'h008

// configuration field positions, per pin n: dir at n, odrain at 4+n, led at 8+n
`define GLED_CFG_DIR_POS 0
`define GLED_CFG_OD_POS  4
`define GLED_CFG_LED_POS 8

// reset values: all pins inputs, push-pull, general-purpose, data low
`define GLED_CFG_RST     32'h0000_0000
`define GLED_DATA_RST    32'h0000_0000

// activity blink timing
`define GLED_CLK_HZ      200000000
`define GLED_BLINK_MS    80
`define GLED_BLINK_CYC   ((`GLED_CLK_HZ / 1000) * `GLED_BLINK_MS)

`endif

//--- src/gled_pkg.sv
package gled_pkg;

  typedef enum logic [1:0] {
    GLED_SPEED_10,
    GLED_SPEED_100,
    GLED_SPEED_ANEG,
    GLED_SPEED_NOLINK
  } gled_speed_t;

  typedef struct packed {
    logic        link_up;
    gled_speed_t speed;
    logic        full_duplex;
    logic        activity;
  } gled_net_status_t;

  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
  } gled_pad_drive_t;

endpackage : gled_pkg

//--- src/gled_port.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Operation
// R01 - each pin: input, push-pull or open-drain
// R02 - each pin may switch to indicator function
// R03 - indicator pins always driven open-drain
// R04 - speed low at 100M/aneg/unplugged, high 10M
// R05 - link-activity low while link valid
// R06 - activity drives it high for 80 ms
// R07 - then low at least 80 ms
// R08 - repeats while activity continues after low period
// R09 - duplex low in full duplex, else high
// R10 - gpio outputs from data, inputs readable

`include "gled_consts.svh"

module gled_port
  import gled_pkg::*;
#(
  parameter int unsigned NPINS     = 3,
  parameter int unsigned BLINK_CYC = `GLED_BLINK_CYC
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // apb slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [11:0]      paddr_i,
  input  wire logic [31:0]      pwdata_i,
  input  wire logic [3:0]       pstrb_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // network status from the phy/mac
  input  wire gled_net_status_t net_status_i,
  // pads
  input  wire logic [NPINS-1:0] pad_i,
  output gled_pad_drive_t       pad_o
);

  localparam int unsigned CW = $clog2(BLINK_CYC + 1);

  // the pin map and the register layout are fixed at three pins
  if (NPINS != 3) begin : g_bad_pins
    $error("gled_port serves exactly three pins");
  end
  // a count below two leaves no room for the reload in the blinker
  if (BLINK_CYC < 2) begin : g_bad_blink
    $error("gled_port blink count too small");
  end

  logic [31:0]      cfg_q;
  logic [31:0]      data_q;
  logic [NPINS-1:0] in_q;
  logic [31:0]      rdata_d;
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;

  // apb slave
  // zero wait states: every access completes in its first access cycle
  // unmapped accesses answer with pslverr and leave every register alone
  // byte lanes follow pstrb; bits with no function read back as zero
  assign pready_o = 1'b1;
  assign wr_en    = psel_i && penable_i && pwrite_i;
  assign rd_en    = psel_i && penable_i && !pwrite_i;
  assign addr_ok  = (paddr_i == `GLED_CFG_OFF) || (paddr_i == `GLED_DATA_OFF) ||
                    (paddr_i == `GLED_STATUS_OFF);
  assign pslverr_o = psel_i && penable_i && !addr_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_q <= `GLED_CFG_RST;
    end else if (wr_en && paddr_i == `GLED_CFG_OFF) begin
      cfg_q <= merge(cfg_q, pwdata_i, pstrb_i) & 32'h0000_0777; // [R01] [R02]
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_q <= `GLED_DATA_RST;
    end else if (wr_en && paddr_i == `GLED_DATA_OFF) begin
      data_q <= merge(data_q, pwdata_i, pstrb_i) & 32'h0000_0007; // [R10]
    end
  end

  // pads are synchronous to clk; one register gives a clean read value
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_q <= '0;
    end else begin
      in_q <= pad_i; // [R10]
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr_i)
      `GLED_CFG_OFF:    rdata_d = cfg_q;
      `GLED_DATA_OFF:   rdata_d = {25'h0, in_q, 1'b0, data_q[2:0]}; // [R10]
      `GLED_STATUS_OFF: rdata_d = {27'h0, net_status_i};
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup cycle, so it stands through the access phase
  // and a pad edge during the access cannot tear the value
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rdata_d;
    end
  end

  // activity blinker
  // activity is a level; one cycle of it is enough to start an off pulse
  // the hold state guarantees the minimum lit time between two off pulses;
  // with steady traffic one solid cycle sits between hold and the next pulse
  // a link drop abandons any pulse in progress and restarts from solid
  typedef enum logic [1:0] {BL_SOLID, BL_OFF, BL_HOLD} gled_blink_t;
  gled_blink_t     bl_q;
  logic [CW-1:0]   bl_cnt_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bl_q     <= BL_SOLID;
      bl_cnt_q <= '0;
    end else if (!net_status_i.link_up) begin
      bl_q     <= BL_SOLID;
      bl_cnt_q <= '0;
    end else begin
      unique case (bl_q)
        BL_SOLID: if (net_status_i.activity) begin
          bl_q     <= BL_OFF; // [R06] [R08]
          bl_cnt_q <= CW'(BLINK_CYC - 1);
        end
        BL_OFF: if (bl_cnt_q == '0) begin
          bl_q     <= BL_HOLD; // [R07]
          bl_cnt_q <= CW'(BLINK_CYC - 1);
        end else begin
          bl_cnt_q <= bl_cnt_q - 1'b1;
        end
        BL_HOLD: if (bl_cnt_q == '0) begin
          bl_q <= BL_SOLID;
        end else begin
          bl_cnt_q <= bl_cnt_q - 1'b1;
        end
      endcase
    end
  end

  // indicator levels (1 = release, 0 = pull low)
  // no link and auto-negotiation both leave the speed lamp lit
  logic [2:0] led_lvl;
  logic       speed_indicator_n;
  logic       link_activity_indicator_n;
  logic       duplex_indicator_n;

  assign speed_indicator_n         = net_status_i.link_up &&
                                     net_status_i.speed == GLED_SPEED_10; // [R04]
  // link down releases the lamp; link up is solid low except during the off pulse
  assign link_activity_indicator_n = !net_status_i.link_up || bl_q == BL_OFF; // [R05] [R06]
  assign duplex_indicator_n        = !(net_status_i.link_up &&
                                       net_status_i.full_duplex); // [R09]
  assign led_lvl = {duplex_indicator_n, link_activity_indicator_n, speed_indicator_n};

  // per-pin drive
  // indicator mode wins over direction and output type
  // data bits only matter while a pin is a gpio output
  logic [2:0] o_d;
  logic [2:0] oe_d;

  for (genvar n = 0; n < NPINS; n++) begin : g_pin
    always_comb begin
      if (cfg_q[`GLED_CFG_LED_POS + n]) begin
        o_d[n]  = 1'b0; // [R02] [R03]
        oe_d[n] = !led_lvl[n];
      end else if (!cfg_q[`GLED_CFG_DIR_POS + n]) begin
        o_d[n]  = 1'b0; // [R01]
        oe_d[n] = 1'b0;
      end else if (cfg_q[`GLED_CFG_OD_POS + n]) begin
        o_d[n]  = 1'b0; // [R01] [R10]
        oe_d[n] = !data_q[n];
      end else begin
        o_d[n]  = data_q[n]; // [R01] [R10]
        oe_d[n] = 1'b1;
      end
    end
  end

  // pads are registered so they never glitch while config or status settle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pad_o <= '0;
    end else begin
      pad_o.o  <= o_d;
      pad_o.oe <= oe_d;
    end
  end

  // assertions
  a_led_opendrain: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R03]
    cfg_q[8] |=> (pad_o.o[0] == 1'b0)) else $error("indicator pin driven high");
  a_speed_level: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R04]
    (cfg_q[8] && net_status_i.speed == GLED_SPEED_100) |=> pad_o.oe[0])
    else $error("speed lamp not low at 100M");
  a_link_solid: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R05]
    (net_status_i.link_up && bl_q != BL_OFF) |-> !link_activity_indicator_n)
    else $error("link lamp not lit");
  a_off_length: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R06]
    (net_status_i.link_up && bl_q == BL_OFF && bl_cnt_q != '0)
      |=> (bl_q == BL_OFF && bl_cnt_q == $past(bl_cnt_q) - 1'b1))
    else $error("off pulse count wrong");
  a_hold_follows: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R07]
    (net_status_i.link_up && bl_q == BL_OFF && bl_cnt_q == '0) |=> bl_q == BL_HOLD)
    else $error("no low hold after off pulse");
  a_reblink: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R08]
    (net_status_i.link_up && bl_q == BL_SOLID && net_status_i.activity) |=> bl_q == BL_OFF)
    else $error("activity did not start a blink");
  a_duplex_level: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R09]
    (cfg_q[10] && !net_status_i.link_up) |=> !pad_o.oe[2])
    else $error("duplex lamp lit without link");
  a_gpio_pushpull: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R10]
    (cfg_q[2:0] == 3'h7 && cfg_q[6:4] == 3'h0 && cfg_q[10:8] == 3'h0)
      |=> (pad_o.oe == 3'h7 && pad_o.o == $past(data_q[2:0])))
    else $error("push-pull output mismatch");
  a_input_float: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R01]
    (cfg_q[10:8] == 3'h0 && cfg_q[2:0] == 3'h0) |=> pad_o.oe == 3'h0)
    else $error("input pin driven");

  // blinker timing
  a_off_start: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R06]
    (net_status_i.link_up && bl_q == BL_SOLID && net_status_i.activity)
      |=> bl_cnt_q == CW'(BLINK_CYC - 1))
    else $error("off pulse count not loaded");
  a_cnt_range: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R06]
    bl_cnt_q <= CW'(BLINK_CYC - 1))
    else $error("blink count out of range");
  a_hold_length: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R07]
    (net_status_i.link_up && bl_q == BL_HOLD && bl_cnt_q != '0)
      |=> (bl_q == BL_HOLD && bl_cnt_q == $past(bl_cnt_q) - 1'b1))
    else $error("low hold cut short");
  a_blink_drop: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R05]
    !net_status_i.link_up |=> bl_q == BL_SOLID)
    else $error("blinker not idle without link");

  // lamp levels
  a_link_released: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R05]
    (cfg_q[9] && !net_status_i.link_up) |=> !pad_o.oe[1])
    else $error("link lamp lit without link");
  a_speed_ten: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R04]
    (cfg_q[8] && net_status_i.link_up && net_status_i.speed == GLED_SPEED_10)
      |=> !pad_o.oe[0])
    else $error("speed lamp lit at 10M");
  a_duplex_full: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R09]
    (cfg_q[10] && net_status_i.link_up && net_status_i.full_duplex) |=> pad_o.oe[2])
    else $error("duplex lamp dark in full duplex");

  // registers and pad sampling
  a_input_sample: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R10]
    1'b1 |=> in_q == $past(pad_i))
    else $error("input sample lost");
  a_unmapped_write: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R01]
    (wr_en && !addr_ok) |=> ($stable(cfg_q) && $stable(data_q)))
    else $error("unmapped write changed a register");

  // per-pin drive checks
  for (genvar n = 0; n < NPINS; n++) begin : g_pin_chk
    a_pin_led_od: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R03]
      cfg_q[`GLED_CFG_LED_POS + n] |=> pad_o.o[n] == 1'b0)
      else $error("indicator pin driven high");
    a_pin_od_gpio: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R01]
      (!cfg_q[`GLED_CFG_LED_POS + n] && cfg_q[`GLED_CFG_DIR_POS + n] &&
       cfg_q[`GLED_CFG_OD_POS + n])
        |=> (pad_o.o[n] == 1'b0 && pad_o.oe[n] == !$past(data_q[n])))
      else $error("open-drain output mismatch");
    a_pin_input: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R01]
      (!cfg_q[`GLED_CFG_LED_POS + n] && !cfg_q[`GLED_CFG_DIR_POS + n]) |=> !pad_o.oe[n])
      else $error("input pin driven");
  end

  c_blink: cover property (@(posedge clk_i) disable iff (!resetn_i)
    bl_q == BL_OFF ##1 bl_q == BL_HOLD);
  c_led_mode: cover property (@(posedge clk_i) disable iff (!resetn_i) cfg_q[10:8] == 3'h7);
  c_od_out: cover property (@(posedge clk_i) disable iff (!resetn_i)
    cfg_q[0] && cfg_q[4] && !cfg_q[8]);
  c_link_drop: cover property (@(posedge clk_i) disable iff (!resetn_i)
    bl_q == BL_OFF ##1 !net_status_i.link_up);
  c_reblink: cover property (@(posedge clk_i) disable iff (!resetn_i)
    bl_q == BL_HOLD ##1 bl_q == BL_SOLID ##1 bl_q == BL_OFF);

endmodule : gled_port

//--- verif/gled_board.sv
`timescale 1ns/1ps
// lamps hang from a pull-up, so a released pin reads high; the board may also
// pull a pin low to act as an external input source
module gled_board
  import gled_pkg::*;
(
  // pin drive from the port
  input  wire gled_pad_drive_t pad_i,
  input  wire logic [2:0]      pull_low_i,
  // resolved wire level
  output logic      [2:0]      level_o
);
  assign level_o = ~((pad_i.oe & ~pad_i.o) | pull_low_i);
endmodule : gled_board

//--- verif/testbench.sv
`timescale 1ns/1ps
`include "gled_consts.svh"
module testbench;
  import gled_pkg::*;
  localparam int BLINK = 20;
  logic             clk_i    = 1'b0;
  logic             resetn_i = 1'b0;
  logic             psel     = 1'b0;
  logic             penable  = 1'b0;
  logic             pwrite   = 1'b0;
  logic [11:0]      paddr    = 12'h000;
  logic [31:0]      pwdata   = 32'h0;
  gled_net_status_t net      = '0;
  logic [2:0]       pull_low = 3'h0;
  logic [2:0]       lvl;
  logic [31:0]      prdata;
  logic [31:0]      rd;
  logic             pready;
  logic             pslverr;
  logic             last_err;
  gled_pad_drive_t  pad;
  int               mismatches = 0;
  int               samples_checked = 0;

  always #2.5 clk_i = ~clk_i;

  gled_port #(.BLINK_CYC(BLINK)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .net_status_i(net), .pad_i(lvl), .pad_o(pad));
  gled_board board (.pad_i(pad), .pull_low_i(pull_low), .level_o(lvl));

  task final_report;
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("mismatch t=%0t bus wait ran out", $time);
      final_report;
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  // width of the current level on the link/activity lamp, bounded
  task width(input logic v, output int n);
    n = 0;
    while (lvl[1] === v && n < 100) begin
      @(posedge clk_i);
      n++;
    end
  endtask : width

  task t_reset;
    chk({26'h0, pad}, 32'h0);
    apb(1'b0, `GLED_CFG_OFF, 32'h0, rd);
    chk(rd, 32'h0);
    apb(1'b0, `GLED_DATA_OFF, 32'h0, rd);
    chk(rd, 32'h70);
    apb(1'b0, 12'h00c, 32'h0, rd);
    chk({rd[30:0], last_err}, 32'h1);
  endtask : t_reset

  task t_gpio;
    apb(1'b1, `GLED_CFG_OFF, 32'h7, rd);
    apb(1'b1, `GLED_DATA_OFF, 32'h5, rd);
    wt(2);
    chk({26'h0, pad.oe, pad.o}, 32'h3d);
    apb(1'b1, `GLED_CFG_OFF, 32'h77, rd);
    wt(2);
    chk({26'h0, pad.oe, lvl}, 32'h15);
    apb(1'b1, `GLED_CFG_OFF, 32'h0, rd);
    pull_low <= 3'h3;
    wt(4);
    apb(1'b0, `GLED_DATA_OFF, 32'h0, rd);
    chk(rd, 32'h45);
    pull_low <= 3'h0;
  endtask : t_gpio

  task t_ind;
    logic [1:0] s;
    apb(1'b1, `GLED_CFG_OFF, 32'h707, rd);
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      net <= '{link_up: 1'b1, speed: gled_speed_t'(s), full_duplex: s[0], activity: 1'b0};
      wt(3);
      chk({26'h0, pad.oe, pad.o & pad.oe}, {26'h0, s[0], 1'b1, s != 2'd0, 3'h0});
    end
    apb(1'b0, `GLED_STATUS_OFF, 32'h0, rd);
    chk(rd, {27'h0, net});
  endtask : t_ind

  task t_blink;
    int n;
    net.activity <= 1'b1;
    width(1'b0, n);
    width(1'b1, n);
    chk(n, BLINK);
    // steady traffic: the hold plus one solid cycle before the next pulse
    width(1'b0, n);
    chk(n, BLINK + 1);
    width(1'b1, n);
    chk(n, BLINK);
    net.activity <= 1'b0;
  endtask : t_blink

  // link lost in the middle of an off pulse
  task t_link;
    wt(BLINK + 4);
    net.activity <= 1'b1;
    wt(4);
    net <= '{link_up: 1'b0, speed: GLED_SPEED_NOLINK, full_duplex: 1'b0, activity: 1'b0};
    wt(3);
    chk({29'h0, pad.oe}, 32'h1);
    chk({29'h0, lvl}, 32'h6);
  endtask : t_link

  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset;
    t_gpio;
    t_ind;
    t_blink;
    t_link;
    final_report;
  end
endmodule : testbench
